/* tb/dca_link_asserts.sv */
// Concurrent checks on the command and address link between the two ends.
`include "dca_consts.svh"
module dca_link_asserts (
  input wire logic                   clk,
  input wire logic                   srst,
  input wire logic                   clock_true,
  input wire logic                   clock_complement,
  input wire logic                   cke,
  input wire logic                   chip_select_n,
  input wire logic                   row_strobe_n,
  input wire logic                   col_strobe_n,
  input wire logic                   write_cmd_n,
  input wire logic [`DCA_ADDR_W-1:0] addr,
  input wire logic [`DCA_BANK_W-1:0] bank_select,
  input wire logic                   write_mask,
  input wire logic                   termination_enable,
  input wire logic                   termination_strobe,
  input wire logic                   reset_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Link checks.
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  chk_clock_pair_inverse: assert property (clock_complement == !clock_true)
    else $error("clock pair not complementary");
  chk_link_clock_toggle: assert property (!$past(srst) |-> clock_true != $past(clock_true))
    else $error("link clock did not toggle");
  chk_pins_hold_rise: assert property ($rose(clock_true) |->
    $stable({chip_select_n, row_strobe_n, col_strobe_n, write_cmd_n, addr, bank_select}))
    else $error("command pins moved at the sampling crossing");
  chk_cke_moves_fall: assert property ($changed(cke) |-> $fell(clock_true))
    else $error("clock enable moved away from a falling link clock");
  chk_mask_moves_fall: assert property ($changed(write_mask) |-> $fell(clock_true))
    else $error("write mask moved away from a falling link clock");
  chk_reset_cmd_idle: assert property ($fell(srst) |->
    &{chip_select_n, row_strobe_n, col_strobe_n, write_cmd_n})
    else $error("command pins not idle after reset");
  chk_reset_cke_low: assert property ($fell(srst) |-> !cke)
    else $error("clock enable not low after reset");
  chk_reset_odt_low: assert property ($fell(srst) |-> !termination_enable)
    else $error("termination enable not low after reset");
  chk_reset_pin_low: assert property ($fell(srst) |-> $rose(reset_n))
    else $error("reset pin not held through reset and released with it");
  chk_reset_pin_stays: assert property ($past(reset_n) |-> reset_n)
    else $error("reset pin asserted again without reset");
  cover property ($rose(clock_true) && !chip_select_n && row_strobe_n && !col_strobe_n
    && !write_cmd_n);
  cover property ($rose(clock_true) && !chip_select_n && !row_strobe_n && col_strobe_n
    && !write_cmd_n && addr[`DCA_AUTOPRE_BIT]);
  cover property ($fell(cke));
  cover property ($rose(termination_strobe));
endmodule

/* tb/dram_command_address_inputs_tb.sv */
// Self-checking bench joining the controller end to the memory end.
`include "dca_consts.svh"
module dram_command_address_inputs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                    clk, srst, req_valid, req_ready, req_auto_pre, req_eight, req_cke;
  logic                    req_mask, req_term, write_beat, cmd_valid, auto_precharge_bit;
  logic                    precharge_all, burst_of_eight, circuits_enabled, termination_on;
  logic                    write_beat_kept, seen, strobe_clock, strobe_prev;
  dca_pkg::dca_cmd_type    req_cmd, cmd, c;
  dca_pkg::dca_power_type  power_state;
  logic [`DCA_BANK_W-1:0]  req_bank, cmd_bank;
  logic [`DCA_ADDR_W-1:0]  req_addr, row_addr, col_addr, a;
  logic [`DCA_NUM_BANKS-1:0] bank_open;
  logic [`DCA_MR_W-1:0]    mode_reg_0, mode_reg_1, mode_reg_2, mode_reg_3;
  logic [15:0]             lfsr = 16'h5290;
  int                      n_fail = 0;
  int                      n_checks = 0;
  dca_link_if dca_link_if_inst ();
  dca_ctrl_end dca_ctrl_end_inst (.clk, .srst, .link(dca_link_if_inst), .req_valid, .req_ready,
    .req_cmd, .req_bank, .req_addr, .req_auto_pre, .req_eight, .req_cke, .req_mask, .req_term);
  dca_mem_end dca_mem_end_inst (.clk, .srst, .link(dca_link_if_inst), .write_beat, .cmd_valid,
    .cmd, .cmd_bank, .row_addr, .col_addr, .auto_precharge_bit, .precharge_all,
    .burst_of_eight, .bank_open, .mode_reg_0, .mode_reg_1, .mode_reg_2, .mode_reg_3,
    .power_state, .circuits_enabled, .termination_on, .write_beat_kept, .strobe_clock);
  dca_link_asserts dca_link_asserts_inst (.clk, .srst,
    .clock_true(dca_link_if_inst.clock_true), .clock_complement(dca_link_if_inst.clock_complement),
    .cke(dca_link_if_inst.cke), .chip_select_n(dca_link_if_inst.chip_select_n),
    .row_strobe_n(dca_link_if_inst.row_strobe_n), .col_strobe_n(dca_link_if_inst.col_strobe_n),
    .write_cmd_n(dca_link_if_inst.write_cmd_n), .addr(dca_link_if_inst.addr),
    .bank_select(dca_link_if_inst.bank_select), .write_mask(dca_link_if_inst.write_mask),
    .termination_enable(dca_link_if_inst.termination_enable),
    .termination_strobe(dca_link_if_inst.termination_strobe),
    .reset_n(dca_link_if_inst.reset_n));
  // ----------------------------------------
  // Helpers.
  // ----------------------------------------
  function automatic logic [15:0] next_rand(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [13:0] exp_col(logic [13:0] v);
    return v & 14'h2BFF;
  endfunction
  function automatic logic [13:0] mr_op(int i);
    return (i == 0) ? 14'h0001 : (i == 1) ? 14'h0000 : 14'h2A50 | 14'(i);
  endfunction
  function automatic logic [15:0] mr_sel(int i);
    return (i == 0) ? mode_reg_0 : (i == 1) ? mode_reg_1 : (i == 2) ? mode_reg_2 : mode_reg_3;
  endfunction
  task automatic chk_val(string what, logic [15:0] exp, logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic send(dca_pkg::dca_cmd_type k, logic [2:0] b, logic [13:0] v, logic auto_pre,
                      logic eight, logic ck);
    req_cmd <= k;
    req_bank <= b;
    req_addr <= v;
    req_auto_pre <= auto_pre;
    req_eight <= eight;
    req_cke <= ck;
    req_valid <= 1'b1;
    @(negedge clk);
    while (req_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    req_valid <= 1'b0;
    seen = 1'b0;
    repeat (12) begin
      @(negedge clk);
      if (cmd_valid === 1'b1) seen = 1'b1;
    end
    @(posedge clk);
  endtask
  task automatic beat(logic exp);
    write_beat <= 1'b1;
    @(posedge clk);
    write_beat <= 1'b0;
    seen = 1'b0;
    repeat (6) begin
      @(negedge clk);
      if (write_beat_kept === 1'b1) seen = 1'b1;
    end
    @(posedge clk);
    chk_val("kept beat", 16'(exp), 16'(seen));
  endtask
  // ----------------------------------------
  // Stimulus.
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    give_verdict();
  end
  initial begin
    {srst, req_eight, req_cke} = 3'h7;
    {req_valid, req_auto_pre, req_mask, req_term, write_beat} = 5'h00;
    req_cmd = dca_pkg::dca_cmd_nop;
    req_bank = 3'h0;
    req_addr = 14'h0000;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    repeat (30) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      send(dca_pkg::dca_cmd_mrs, i[2:0], mr_op(i), 1'b0, 1'b1, 1'b1);
      chk_val("mode register", {2'h0, mr_op(i)}, mr_sel(i));
    end
    $display("test mode done");
    for (int k = 0; k < 30; k++) begin
      lfsr = next_rand(lfsr);
      c = (lfsr[1:0] == 2'h1) ? dca_pkg::dca_cmd_rd :
          (lfsr[1:0] == 2'h2) ? dca_pkg::dca_cmd_wr : dca_pkg::dca_cmd_act;
      a = (k == 0) ? 14'h3FFF : 14'(next_rand(lfsr) ^ 16'(k));
      send(c, (k == 0) ? 3'h7 : lfsr[4:2], a, lfsr[5], lfsr[6], 1'b1);
      chk_val("command", 16'(c), 16'(cmd));
      chk_val("bank", 16'((k == 0) ? 3'h7 : lfsr[4:2]), 16'(cmd_bank));
      if (c == dca_pkg::dca_cmd_act) begin
        chk_val("row", 16'(a), 16'(row_addr));
      end else begin
        chk_val("column", 16'(exp_col(a) | {1'b0, lfsr[6], 12'h000}), 16'(col_addr));
        chk_val("auto precharge", 16'(lfsr[5]), 16'(auto_precharge_bit));
        chk_val("burst of eight", 16'(lfsr[6]), 16'(burst_of_eight));
      end
    end
    send(dca_pkg::dca_cmd_zq, 3'h2, 14'h0400, 1'b0, 1'b1, 1'b1);
    chk_val("command", 16'(dca_pkg::dca_cmd_zq), 16'(cmd));
    send(dca_pkg::dca_cmd_ref, 3'h0, 14'h0000, 1'b0, 1'b1, 1'b1);
    chk_val("command", 16'(dca_pkg::dca_cmd_ref), 16'(cmd));
    send(dca_pkg::dca_cmd_mrs, 3'h0, 14'h0000, 1'b0, 1'b1, 1'b1);
    send(dca_pkg::dca_cmd_rd, 3'h1, 14'h1055, 1'b0, 1'b0, 1'b1);
    chk_val("burst of eight", 16'h0001, 16'(burst_of_eight));
    $display("test random done");
    send(dca_pkg::dca_cmd_pre, 3'h3, 14'h0000, 1'b0, 1'b1, 1'b1);
    chk_val("precharge all", 16'h0000, 16'(precharge_all));
    chk_val("bank three open", 16'h0000, 16'(bank_open[3]));
    send(dca_pkg::dca_cmd_pre, 3'h5, 14'h0000, 1'b1, 1'b1, 1'b1);
    chk_val("precharge all", 16'h0001, 16'(precharge_all));
    chk_val("open banks", 16'h0000, 16'(bank_open));
    send(dca_pkg::dca_cmd_desel, 3'h1, 14'h0040, 1'b0, 1'b1, 1'b1);
    chk_val("deselect decoded", 16'h0000, 16'(seen));
    $display("test precharge done");
    send(dca_pkg::dca_cmd_act, 3'h2, 14'h0123, 1'b0, 1'b1, 1'b1);
    send(dca_pkg::dca_cmd_nop, 3'h0, 14'h0000, 1'b0, 1'b1, 1'b0);
    chk_val("power", 16'(dca_pkg::dca_pw_powerdown), 16'(power_state));
    chk_val("circuits", 16'h0000, 16'(circuits_enabled));
    send(dca_pkg::dca_cmd_act, 3'h4, 14'h0321, 1'b0, 1'b1, 1'b0);
    chk_val("power down decoded", 16'h0000, 16'(seen));
    send(dca_pkg::dca_cmd_nop, 3'h0, 14'h0000, 1'b0, 1'b1, 1'b1);
    chk_val("power", 16'(dca_pkg::dca_pw_active), 16'(power_state));
    chk_val("circuits", 16'h0001, 16'(circuits_enabled));
    send(dca_pkg::dca_cmd_pre, 3'h0, 14'h0000, 1'b1, 1'b1, 1'b1);
    send(dca_pkg::dca_cmd_ref, 3'h0, 14'h0000, 1'b0, 1'b1, 1'b0);
    chk_val("power", 16'(dca_pkg::dca_pw_selfrefresh), 16'(power_state));
    send(dca_pkg::dca_cmd_nop, 3'h0, 14'h0000, 1'b0, 1'b1, 1'b1);
    chk_val("power", 16'(dca_pkg::dca_pw_active), 16'(power_state));
    $display("test power done");
    req_term <= 1'b1;
    req_mask <= 1'b1;
    send(dca_pkg::dca_cmd_nop, 3'h0, 14'h0000, 1'b0, 1'b1, 1'b1);
    chk_val("termination", 16'h0001, 16'(termination_on));
    beat(1'b0);
    req_mask <= 1'b0;
    send(dca_pkg::dca_cmd_nop, 3'h0, 14'h0000, 1'b0, 1'b1, 1'b1);
    beat(1'b1);
    send(dca_pkg::dca_cmd_mrs, 3'h1, 14'h0001, 1'b0, 1'b1, 1'b1);
    chk_val("termination", 16'h0000, 16'(termination_on));
    req_mask <= 1'b1;
    send(dca_pkg::dca_cmd_mrs, 3'h1, 14'h0800, 1'b0, 1'b1, 1'b1);
    beat(1'b1);
    chk_val("termination strobe", 16'h0001, 16'(dca_link_if_inst.termination_strobe));
    @(negedge clk);
    strobe_prev = strobe_clock;
    @(negedge clk);
    chk_val("strobe toggle", 16'h0001, 16'(strobe_prev ^ strobe_clock));
    @(posedge clk);
    $display("test termination done");
    give_verdict();
  end
endmodule

/* verilog/dca_consts.svh */
// Constants shared by the command/address link ends.
`ifndef DCA_CONSTS_SVH
`define DCA_CONSTS_SVH
`define DCA_ADDR_W        14
`define DCA_BANK_W        3
`define DCA_DQ_W          8
`define DCA_AUTOPRE_BIT   10
`define DCA_CHOP_BIT      12
`define DCA_NUM_BANKS     8
`define DCA_MR_W          16
`define DCA_TERM_OFF_BIT  0
`define DCA_TSTRB_EN_BIT  11
`define DCA_OTF_EN_BIT    0
`endif

/* verilog/dca_ctrl_end.sv */
// Controller end: drives the command, address and control pins.
`include "dca_consts.svh"
module dca_ctrl_end (
  input  wire logic                     clk,
  input  wire logic                     srst,
  dca_link_if.ctrl                      link,
  input  wire logic                     req_valid,
  output logic                          req_ready,
  input  dca_pkg::dca_cmd_type          req_cmd,
  input  wire logic [`DCA_BANK_W-1:0]   req_bank,
  input  wire logic [`DCA_ADDR_W-1:0]   req_addr,
  input  wire logic                     req_auto_pre,
  input  wire logic                     req_eight,
  input  wire logic                     req_cke,
  input  wire logic                     req_mask,
  input  wire logic                     req_term
);
  logic                    phase;
  logic                    next_phase;
  logic [3:0]              cmd_pins;
  logic [3:0]              next_cmd_pins;
  logic [`DCA_ADDR_W-1:0]  a;
  logic [`DCA_ADDR_W-1:0]  next_a;
  logic [`DCA_BANK_W-1:0]  ba;
  logic [`DCA_BANK_W-1:0]  next_ba;
  logic                    cke;
  logic                    next_cke;
  logic                    mask_q;
  logic                    next_mask_q;
  logic                    term_q;
  logic                    next_term_q;

  // ---------------------------------------------------------------
  // Command is launched on the falling link clock, held for a period.
  // ---------------------------------------------------------------
  assign req_ready = phase;

  always_comb begin
    next_phase    = ~phase;
    next_cmd_pins = cmd_pins;
    next_a        = a;
    next_ba       = ba;
    next_cke      = cke;
    next_mask_q   = mask_q;
    next_term_q   = term_q;
    if (phase) begin
      next_cmd_pins = 4'hF;
      next_cke      = req_cke;
      next_term_q   = req_term;
      next_mask_q   = req_mask;
      if (req_valid) begin
        next_ba = req_bank;
        next_a  = req_addr;
        case (req_cmd)
          dca_pkg::dca_cmd_mrs: next_cmd_pins = 4'h0;
          dca_pkg::dca_cmd_ref: next_cmd_pins = 4'h1;
          dca_pkg::dca_cmd_pre: next_cmd_pins = 4'h2;
          dca_pkg::dca_cmd_act: next_cmd_pins = 4'h3;
          dca_pkg::dca_cmd_wr:  next_cmd_pins = 4'h4;
          dca_pkg::dca_cmd_rd:  next_cmd_pins = 4'h5;
          dca_pkg::dca_cmd_zq:  next_cmd_pins = 4'h6;
          dca_pkg::dca_cmd_nop: next_cmd_pins = 4'h7;
          default:              next_cmd_pins = 4'hF;
        endcase
        if (req_cmd == dca_pkg::dca_cmd_rd || req_cmd == dca_pkg::dca_cmd_wr ||
            req_cmd == dca_pkg::dca_cmd_pre) begin
          next_a[`DCA_AUTOPRE_BIT] = req_auto_pre;
        end
        if (req_cmd == dca_pkg::dca_cmd_rd || req_cmd == dca_pkg::dca_cmd_wr) begin
          next_a[`DCA_CHOP_BIT] = req_eight;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      phase    <= 1'b0;
      cmd_pins <= 4'hF;
      a        <= '0;
      ba       <= '0;
      cke      <= 1'b0;
      mask_q   <= 1'b0;
      term_q   <= 1'b0;
    end else begin
      phase    <= next_phase;
      cmd_pins <= next_cmd_pins;
      a        <= next_a;
      ba       <= next_ba;
      cke      <= next_cke;
      mask_q   <= next_mask_q;
      term_q   <= next_term_q;
    end
  end

  assign link.clock_true         = phase;
  assign link.clock_complement   = ~phase;
  assign link.chip_select_n      = cmd_pins[3];
  assign link.row_strobe_n       = cmd_pins[2];
  assign link.col_strobe_n       = cmd_pins[1];
  assign link.write_cmd_n        = cmd_pins[0];
  assign link.addr               = a;
  assign link.bank_select        = ba;
  assign link.cke                = cke;
  assign link.write_mask         = mask_q;
  assign link.termination_enable = term_q;
  assign link.reset_n            = ~srst;
endmodule

/* verilog/dca_link_if.sv */
// Interface joining controller and memory command/address pins.
`include "dca_consts.svh"
interface dca_link_if;
  logic                      clock_true;
  logic                      clock_complement;
  logic                      cke;
  logic                      chip_select_n;
  logic                      row_strobe_n;
  logic                      col_strobe_n;
  logic                      write_cmd_n;
  logic [`DCA_ADDR_W-1:0]    addr;
  logic [`DCA_BANK_W-1:0]    bank_select;
  logic                      write_mask;
  logic                      termination_enable;
  logic                      termination_strobe;
  logic                      reset_n;

  modport ctrl (
    output clock_true, clock_complement, cke, chip_select_n, row_strobe_n,
    output col_strobe_n, write_cmd_n, addr, bank_select, write_mask,
    output termination_enable, reset_n,
    input  termination_strobe
  );
  modport mem (
    input  clock_true, clock_complement, cke, chip_select_n, row_strobe_n,
    input  col_strobe_n, write_cmd_n, addr, bank_select, write_mask,
    input  termination_enable, reset_n,
    output termination_strobe
  );
endinterface

/* verilog/dca_mem_end.sv */
// Memory end: samples command, address and control pins and decodes them.
`include "dca_consts.svh"
module dca_mem_end (
  input  wire logic                       clk,
  input  wire logic                       srst,
  dca_link_if.mem                         link,
  input  wire logic                       write_beat,
  output logic                            cmd_valid,
  output dca_pkg::dca_cmd_type            cmd,
  output logic [`DCA_BANK_W-1:0]          cmd_bank,
  output logic [`DCA_ADDR_W-1:0]          row_addr,
  output logic [`DCA_ADDR_W-1:0]          col_addr,
  output logic                            auto_precharge_bit,
  output logic                            precharge_all,
  output logic                            burst_of_eight,
  output logic [`DCA_NUM_BANKS-1:0]       bank_open,
  output logic [`DCA_MR_W-1:0]            mode_reg_0,
  output logic [`DCA_MR_W-1:0]            mode_reg_1,
  output logic [`DCA_MR_W-1:0]            mode_reg_2,
  output logic [`DCA_MR_W-1:0]            mode_reg_3,
  output dca_pkg::dca_power_type          power_state,
  output logic                            circuits_enabled,
  output logic                            termination_on,
  output logic                            write_beat_kept,
  output logic                            strobe_clock
);
  localparam int SW = 9 + `DCA_ADDR_W + `DCA_BANK_W;
  logic [SW-1:0]               raw_pins;
  logic [SW-1:0]               pins;
  logic                        ck_s;
  logic                        ck_prev;
  logic                        next_ck_prev;
  logic                        rise;
  logic                        cke_s;
  logic                        cs_n_s;
  logic                        ras_n_s;
  logic                        cas_n_s;
  logic                        we_n_s;
  logic                        mask_s;
  logic                        term_s;
  logic                        rst_n_s;
  logic [`DCA_ADDR_W-1:0]      a_s;
  logic [`DCA_BANK_W-1:0]      ba_s;
  logic                        cke_reg;
  logic                        next_cke_reg;
  dca_pkg::dca_cmd_type        dec;
  dca_pkg::dca_cmd_type        next_cmd;
  logic                        next_cmd_valid;
  logic [`DCA_BANK_W-1:0]      next_cmd_bank;
  logic [`DCA_ADDR_W-1:0]      next_row_addr;
  logic [`DCA_ADDR_W-1:0]      next_col_addr;
  logic                        next_auto_pre;
  logic                        next_pall;
  logic                        next_eight;
  logic [`DCA_NUM_BANKS-1:0]   next_bank_open;
  logic [`DCA_MR_W-1:0]        next_mr [4];
  logic [`DCA_MR_W-1:0]        mr [4];
  dca_pkg::dca_power_type      next_power;
  logic                        next_term;
  logic                        next_kept;
  logic                        in_reset;

  // ---------------------------------------------------------------
  // Pin synchronisation.
  // ---------------------------------------------------------------
  assign raw_pins = {link.clock_true, link.cke, link.chip_select_n, link.row_strobe_n,
                     link.col_strobe_n, link.write_cmd_n, link.write_mask,
                     link.termination_enable, link.reset_n, link.addr, link.bank_select};

  dca_sync2 #(.W(SW)) dca_sync2_inst (
    .clk  (clk),
    .srst (srst),
    .d    (raw_pins),
    .q    (pins)
  );

  assign {ck_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, mask_s, term_s, rst_n_s, a_s, ba_s} = pins;
  // Complement is redundant with the true phase once synchronised.
  assign rise     = ck_s & ~ck_prev;
  assign in_reset = srst | ~rst_n_s;

  // ---------------------------------------------------------------
  // Command decode.
  // ---------------------------------------------------------------
  always_comb begin
    dec = dca_pkg::dca_cmd_desel;
    if (!cs_n_s) begin
      case ({ras_n_s, cas_n_s, we_n_s})
        3'h0:    dec = dca_pkg::dca_cmd_mrs;
        3'h1:    dec = dca_pkg::dca_cmd_ref;
        3'h2:    dec = dca_pkg::dca_cmd_pre;
        3'h3:    dec = dca_pkg::dca_cmd_act;
        3'h4:    dec = dca_pkg::dca_cmd_wr;
        3'h5:    dec = dca_pkg::dca_cmd_rd;
        3'h6:    dec = dca_pkg::dca_cmd_zq;
        default: dec = dca_pkg::dca_cmd_nop;
      endcase
    end
  end

  always_comb begin
    next_ck_prev   = ck_s;
    next_cke_reg   = cke_reg;
    next_cmd_valid = 1'b0;
    next_cmd       = cmd;
    next_cmd_bank  = cmd_bank;
    next_row_addr  = row_addr;
    next_col_addr  = col_addr;
    next_auto_pre  = auto_precharge_bit;
    next_pall      = precharge_all;
    next_eight     = burst_of_eight;
    next_bank_open = bank_open;
    next_power     = power_state;
    next_term      = termination_on;
    next_kept      = 1'b0;
    for (int i = 0; i < 4; i++) begin
      next_mr[i] = mr[i];
    end
    if (power_state == dca_pkg::dca_pw_selfrefresh) begin
      if (cke_s) begin
        next_power   = dca_pkg::dca_pw_active;
        next_cke_reg = 1'b1;
      end
      next_term = 1'b0;
    end else if (rise) begin
      next_cke_reg = cke_s;
      if (power_state == dca_pkg::dca_pw_powerdown) begin
        if (cke_s) begin
          next_power = dca_pkg::dca_pw_active;
        end
      end else if (!cke_s) begin
        if (dec == dca_pkg::dca_cmd_ref && bank_open == '0) begin
          next_power = dca_pkg::dca_pw_selfrefresh;
        end else begin
          next_power = dca_pkg::dca_pw_powerdown;
        end
      end else if (cke_reg && dec != dca_pkg::dca_cmd_desel) begin
        next_cmd_valid = 1'b1;
        next_cmd       = dec;
        next_cmd_bank  = ba_s;
        case (dec)
          dca_pkg::dca_cmd_act: begin
            next_row_addr         = a_s;
            next_bank_open[ba_s]  = 1'b1;
          end
          dca_pkg::dca_cmd_rd, dca_pkg::dca_cmd_wr: begin
            next_col_addr = a_s;
            next_col_addr[`DCA_AUTOPRE_BIT] = 1'b0;
            next_auto_pre = a_s[`DCA_AUTOPRE_BIT];
            if (mr[0][`DCA_OTF_EN_BIT]) begin
              next_eight = a_s[`DCA_CHOP_BIT];
            end else begin
              next_eight = 1'b1;
            end
            if (a_s[`DCA_AUTOPRE_BIT]) begin
              next_bank_open[ba_s] = 1'b0;
            end
          end
          dca_pkg::dca_cmd_pre: begin
            next_pall = a_s[`DCA_AUTOPRE_BIT];
            if (a_s[`DCA_AUTOPRE_BIT]) begin
              next_bank_open = '0;
            end else begin
              next_bank_open[ba_s] = 1'b0;
            end
          end
          dca_pkg::dca_cmd_mrs: begin
            next_mr[ba_s[1:0]] = `DCA_MR_W'(a_s);
          end
          default: begin
            next_cmd_valid = 1'b1;
          end
        endcase
      end
      if (power_state != dca_pkg::dca_pw_selfrefresh) begin
        next_term = term_s & ~mr[1][`DCA_TERM_OFF_BIT];
      end
    end
    if (write_beat && !mr[1][`DCA_TSTRB_EN_BIT]) begin
      next_kept = ~mask_s;
    end else if (write_beat) begin
      next_kept = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (in_reset) begin
      ck_prev            <= 1'b0;
      cke_reg            <= 1'b0;
      cmd_valid          <= 1'b0;
      cmd                <= dca_pkg::dca_cmd_desel;
      cmd_bank           <= '0;
      row_addr           <= '0;
      col_addr           <= '0;
      auto_precharge_bit <= 1'b0;
      precharge_all      <= 1'b0;
      burst_of_eight     <= 1'b1;
      bank_open          <= '0;
      power_state        <= dca_pkg::dca_pw_active;
      termination_on     <= 1'b0;
      write_beat_kept    <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        mr[i] <= '0;
      end
    end else begin
      ck_prev            <= next_ck_prev;
      cke_reg            <= next_cke_reg;
      cmd_valid          <= next_cmd_valid;
      cmd                <= next_cmd;
      cmd_bank           <= next_cmd_bank;
      row_addr           <= next_row_addr;
      col_addr           <= next_col_addr;
      auto_precharge_bit <= next_auto_pre;
      precharge_all      <= next_pall;
      burst_of_eight     <= next_eight;
      bank_open          <= next_bank_open;
      power_state        <= next_power;
      termination_on     <= next_term;
      write_beat_kept    <= next_kept;
      for (int i = 0; i < 4; i++) begin
        mr[i] <= next_mr[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs.
  // ---------------------------------------------------------------
  assign mode_reg_0       = mr[0];
  assign mode_reg_1       = mr[1];
  assign mode_reg_2       = mr[2];
  assign mode_reg_3       = mr[3];
  assign circuits_enabled = cke_reg;
  assign strobe_clock     = ck_prev;
  // Termination covers data, strobe and mask while on, or the strobe pins in strobe mode.
  assign link.termination_strobe = termination_on & mr[1][`DCA_TSTRB_EN_BIT];
endmodule

/* verilog/dca_pkg.sv */
// Types shared by the command/address link ends.
package dca_pkg;
  typedef enum logic [3:0] {
    dca_cmd_mrs,
    dca_cmd_ref,
    dca_cmd_pre,
    dca_cmd_act,
    dca_cmd_wr,
    dca_cmd_rd,
    dca_cmd_nop,
    dca_cmd_zq,
    dca_cmd_desel
  } dca_cmd_type;

  typedef enum logic [1:0] {
    dca_pw_active,
    dca_pw_powerdown,
    dca_pw_selfrefresh
  } dca_power_type;
endpackage

/* verilog/dca_sync2.sv */
// Two flip-flop synchroniser for pins entering the clk domain.
module dca_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_q;

  always_comb begin
    next_stage1 = d;
    next_q      = stage1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      stage1 <= '0;
      q      <= '0;
    end else begin
      stage1 <= next_stage1;
      q      <= next_q;
    end
  end
endmodule
